/* File: logic/timer_defines.svh */
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// register indices; the byte address on the bus is four times the index
`define IDX_COUNT        12'h001
`define IDX_INTCTL       12'h00B
`define IDX_OPTION       12'h081
`define IDX_CTRL         12'h090

// field positions
`define INTCTL_FLAG_BIT  2
`define INTCTL_EN_BIT    5
`define CTRL_SLEEP_BIT   0
`define CTRL_WDCLR_BIT   1

// reset values
`define COUNT_RESET      8'h00
`define INTCTL_RESET     8'h00
`define OPTION_RESET     8'hFF
`define CTRL_RESET       8'h00

// inhibit length in instruction cycles, and the counter's top value
`define INHIBIT_CYCLES   2'h2
`define COUNT_MAX        8'hFF

`endif

/* File: logic/timer_pkg.sv */
`default_nettype none
package timer_pkg;

	typedef enum logic [3:0] {
		PH_ONE   = 4'b0001,
		PH_TWO   = 4'b0010,
		PH_THREE = 4'b0100,
		PH_FOUR  = 4'b1000
	} phase_e;

	typedef struct packed {
		logic       pullup_n;
		logic       int_edge;
		logic       clock_source_select;
		logic       source_edge_select;
		logic       prescaler_assign;
		logic [2:0] prescale_rate;
	} option_s;

endpackage : timer_pkg
`default_nettype wire

/* File: logic/timer_counter.sv */
// The AHB-Lite interface to the registers was chosen for this implementation.
`include "timer_defines.svh"
`default_nettype none
module timer_counter (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        external_count_input,
	input  wire logic        watchdog_osc_tick,
	output logic             watchdog_tick_out,
	output logic             watchdog_clear_out,
	output logic             irq
);

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	timer_pkg::phase_e  phase_q;
	timer_pkg::option_s option_q;
	logic [7:0]  count_q;
	logic [7:0]  presc_q;
	logic [7:0]  intctl_q;
	logic        flag_q;
	logic        sleep_q;
	logic [1:0]  inhibit_q;
	logic        samp_q;
	logic        ext_prev_q;
	logic        wr_pend_q;
	logic        rd_pend_q;
	logic        hit_q;
	logic [11:0] idx_q;

	logic        acc;
	logic        wr_count;
	logic        wr_intctl;
	logic        wr_option;
	logic        wr_ctrl;
	logic [7:0]  wdata;
	logic        phase_two_en;
	logic        phase_four_en;
	logic        ext_edge;
	logic        presc_src;
	logic        presc_clr;
	logic        presc_lvl;
	logic        tick_raw;
	logic        tick;
	logic        wdclr;
	logic        flag_set;
	logic        flag_clr;

	function automatic logic sel_reg(input logic hit, input logic [11:0] idx,
		input logic [11:0] want);
		sel_reg = hit && (idx == want);
	endfunction : sel_reg

	function automatic logic [7:0] rate_mask(input logic [2:0] rate);
		rate_mask = ~(8'hFF << rate);
	endfunction : rate_mask

	// four hclk periods form one instruction cycle, one per phase clock
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			phase_q <= timer_pkg::PH_ONE;
		else
			unique case (phase_q)
				timer_pkg::PH_ONE:   phase_q <= timer_pkg::PH_TWO;
				timer_pkg::PH_TWO:   phase_q <= timer_pkg::PH_THREE;
				timer_pkg::PH_THREE: phase_q <= timer_pkg::PH_FOUR;
				timer_pkg::PH_FOUR:  phase_q <= timer_pkg::PH_ONE;
			endcase
	end

	assign phase_two_en  = (phase_q == timer_pkg::PH_TWO);
	assign phase_four_en = (phase_q == timer_pkg::PH_FOUR);

	// bus slave: writes are zero-wait, reads take one wait state so that
	// the read data leaves a flop and sees a write that just finished
	assign acc = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_q <= 1'b0;
			rd_pend_q <= 1'b0;
			hit_q     <= 1'b0;
			idx_q     <= 12'h000;
		end
		else
		begin
			wr_pend_q <= acc && hwrite;
			rd_pend_q <= acc && !hwrite;
			if (acc)
			begin
				hit_q <= (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);
				idx_q <= haddr[13:2];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h00000000;
		end
		else
		begin
			hreadyout <= !(acc && !hwrite);
			hresp     <= 1'b0;
			if (rd_pend_q)
			begin
				// the prescaler has no read path and unmapped words read zero
				hrdata <= 32'h00000000;
				if (sel_reg(hit_q, idx_q, `IDX_COUNT))
					hrdata <= {24'h000000, count_q};
				else if (sel_reg(hit_q, idx_q, `IDX_INTCTL))
					hrdata <= {24'h000000, intctl_q[7:3], flag_q, intctl_q[1:0]};
				else if (sel_reg(hit_q, idx_q, `IDX_OPTION))
					hrdata <= {24'h000000, option_q};
				else if (sel_reg(hit_q, idx_q, `IDX_CTRL))
					hrdata <= {31'h00000000, sleep_q};
			end
		end
	end

	assign wdata     = hwdata[7:0];
	assign wr_count  = wr_pend_q && sel_reg(hit_q, idx_q, `IDX_COUNT);
	assign wr_intctl = wr_pend_q && sel_reg(hit_q, idx_q, `IDX_INTCTL);
	assign wr_option = wr_pend_q && sel_reg(hit_q, idx_q, `IDX_OPTION);
	assign wr_ctrl   = wr_pend_q && sel_reg(hit_q, idx_q, `IDX_CTRL);
	assign wdclr     = wr_ctrl && wdata[`CTRL_WDCLR_BIT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			option_q <= `OPTION_RESET;
		else if (wr_option)
			option_q <= wdata;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sleep_q <= 1'b0;
		else if (wr_ctrl)
			sleep_q <= wdata[`CTRL_SLEEP_BIT];
	end

	// external input edge on the raw pin, rising or falling as the edge select picks
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ext_prev_q <= 1'b0;
		else
			ext_prev_q <= external_count_input;
	end

	assign ext_edge = option_q.source_edge_select ?
		(ext_prev_q && !external_count_input) :
		(!ext_prev_q && external_count_input);

	// one prescaler, fed by whichever side holds it
	always_comb
	begin
		if (option_q.prescaler_assign)
			presc_src = watchdog_osc_tick;
		else if (option_q.clock_source_select)
			presc_src = ext_edge;
		else
			presc_src = phase_four_en && !sleep_q;
	end

	assign presc_clr = (wr_count && !option_q.prescaler_assign) ||
		(wdclr && option_q.prescaler_assign);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			presc_q <= 8'h00;
		else if (presc_clr)
			presc_q <= 8'h00;
		else if (presc_src)
			presc_q <= presc_q + 8'h01;
	end

	// level seen by the sampler: divided bit, or the raw input turned by the edge select
	always_comb
	begin
		if (option_q.prescaler_assign)
			presc_lvl = external_count_input ^ option_q.source_edge_select;
		else
			presc_lvl = presc_q[option_q.prescale_rate];
	end

	// sampling only twice per instruction cycle means input pulses shorter
	// than two hclk periods may be missed entirely
	always_ff @(posedge hclk or negedge hresetn)
	begin
		// starts high so a resting pin after reset never reads as a fresh edge
		if (!hresetn)
			samp_q <= 1'b1;
		else if (phase_two_en || phase_four_en)
			samp_q <= presc_lvl;
	end

	always_comb
	begin
		if (!option_q.clock_source_select && option_q.prescaler_assign)
			tick_raw = phase_four_en;
		else
			tick_raw = (phase_two_en || phase_four_en) && presc_lvl && !samp_q;
	end

	assign tick = tick_raw && !sleep_q && (inhibit_q == 2'h0);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			inhibit_q <= 2'h0;
		else if (wr_count)
			inhibit_q <= `INHIBIT_CYCLES;
		else if (phase_four_en && (inhibit_q != 2'h0))
			inhibit_q <= inhibit_q - 2'h1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_q <= `COUNT_RESET;
		else if (wr_count)
			count_q <= wdata;
		else if (tick)
			count_q <= count_q + 8'h01;
	end

	// overflow flag: a wrap in the clearing cycle still sets it
	assign flag_set = tick && !wr_count && (count_q == `COUNT_MAX);
	assign flag_clr = wr_intctl && wdata[`INTCTL_FLAG_BIT];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			flag_q <= 1'b0;
		else
			flag_q <= flag_set || (flag_q && !flag_clr);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			intctl_q <= `INTCTL_RESET;
		else if (wr_intctl)
			intctl_q <= wdata;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			irq <= 1'b0;
		else
			irq <= flag_q && intctl_q[`INTCTL_EN_BIT];
	end

	// watchdog side: divided when it owns the prescaler, else undivided
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			watchdog_tick_out  <= 1'b0;
			watchdog_clear_out <= 1'b0;
		end
		else
		begin
			watchdog_clear_out <= wdclr;
			if (option_q.prescaler_assign)
				watchdog_tick_out <= watchdog_osc_tick && !presc_clr &&
					((presc_q & rate_mask(option_q.prescale_rate)) ==
					rate_mask(option_q.prescale_rate));
			else
				watchdog_tick_out <= watchdog_osc_tick;
		end
	end

	a_timer_step: assert property (
		phase_four_en && !option_q.clock_source_select && option_q.prescaler_assign &&
		!sleep_q && (inhibit_q == 2'h0) && !wr_count
		|=> count_q == $past(count_q) + 8'h01)
		else $error("timer mode missed an instruction-cycle increment");

	a_write_inhibit: assert property (
		(count_q != $past(count_q)) && !$past(wr_count)
		|-> $past(inhibit_q) == 2'h0)
		else $error("count advanced inside the post-write inhibit");

	a_inhibit_len: assert property (
		wr_count ##1 (!wr_count && phase_four_en) [*1] |=> inhibit_q == 2'h1)
		else $error("inhibit did not start at two cycles");

	a_ext_presc_edge: assert property (
		option_q.clock_source_select && !option_q.prescaler_assign &&
		ext_edge && !presc_clr
		|=> presc_q == $past(presc_q) + 8'h01)
		else $error("external edge not counted by prescaler");

	a_presc_wr_clear: assert property (
		wr_count && !option_q.prescaler_assign |=> presc_q == 8'h00)
		else $error("count write left prescaler uncleared");

	a_presc_wd_clear: assert property (
		wdclr && option_q.prescaler_assign |=> (presc_q == 8'h00) && watchdog_clear_out)
		else $error("watchdog clear left prescaler uncleared");

	a_wrap_sets_flag: assert property (
		($past(count_q) == 8'hFF) && (count_q == 8'h00) && !$past(wr_count)
		|-> flag_q)
		else $error("wrap from all ones did not set flag");

	a_flag_cause: assert property (
		$rose(flag_q) |-> ($past(count_q) == 8'hFF) && $past(tick))
		else $error("flag set without a wrap");

	a_flag_sticky: assert property (
		flag_q && !flag_clr |=> flag_q)
		else $error("flag dropped without software clear");

	a_irq_masked: assert property (
		irq |-> $past(flag_q) && $past(intctl_q[`INTCTL_EN_BIT]))
		else $error("interrupt raised while masked or flag clear");

	a_sleep_frozen: assert property (
		$past(sleep_q) && !$past(wr_count) |-> count_q == $past(count_q))
		else $error("counter moved during sleep");

	a_read_wait: assert property (
		acc && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");

	c_overflow_seen: cover property (flag_set && intctl_q[`INTCTL_EN_BIT]);
	c_ext_falling: cover property (
		option_q.clock_source_select && option_q.source_edge_select && tick);
	c_wd_clear: cover property (wdclr && option_q.prescaler_assign);

endmodule : timer_counter
`default_nettype wire

/* File: verif/count_src.sv */
`default_nettype none
module count_src (
	input  wire logic hclk,
	output var logic  pin
);
	timeunit 1ns;
	timeprecision 100ps;

	initial pin = 1'b0;

	// three cycles per level leaves margin over the two-period minimum
	task automatic pulses(input int n);
		repeat (n)
		begin
			pin <= 1'b1;
			repeat (3) @(posedge hclk);
			pin <= 1'b0;
			repeat (3) @(posedge hclk);
		end
	endtask : pulses

	task automatic level(input logic v);
		pin <= v;
		repeat (3) @(posedge hclk);
	endtask : level
endmodule : count_src
`default_nettype wire

/* File: verif/tb.sv */
`default_nettype none
`define CHK(nm, e, g) \
	begin total_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [31:0] A_CNT = 32'h0000_0004;
	localparam logic [31:0] A_INT = 32'h0000_002C;
	localparam logic [31:0] A_OPT = 32'h0000_0204;
	localparam logic [31:0] A_CTL = 32'h0000_0240;
	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
	logic        osc, wd_tick, wd_clr, irq, pin;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, d0, d1;
	int          n_errors, total_checks, cyc, n_tick, n_clr, n_resp;

	count_src src (.hclk(hclk), .pin(pin));

	timer_counter dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.external_count_input(pin), .watchdog_osc_tick(osc),
		.watchdog_tick_out(wd_tick), .watchdog_clear_out(wd_clr), .irq(irq)
	);

	initial
	begin
		hclk = 1'b0;
		forever #2 hclk = ~hclk;
	end

	always @(posedge hclk)
	begin
		cyc++;
		n_tick += (wd_tick === 1'b1);
		n_clr += (wd_clr === 1'b1);
		n_resp += (hresp !== 1'b0);
		if (cyc == 20000)
		begin
			n_errors++;
			conclude();
		end
	end

	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : conclude

	task automatic wr(input logic [31:0] a, input logic [7:0] v);
		haddr <= a;
		hwrite <= 1'b1;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h00_0000, v};
		do @(posedge hclk); while (hreadyout !== 1'b1);
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		haddr <= a;
		hwrite <= 1'b0;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		d = hrdata;
	endtask : rd

	task automatic chk_rd(input logic [31:0] a, input logic [31:0] e, input string nm);
		rd(a, d0);
		`CHK(nm, e, d0)
	endtask : chk_rd

	// count change across a fixed gap; both reads take the same number of cycles
	task automatic delta(input int gap, input logic [7:0] e, input string nm);
		rd(A_CNT, d0);
		repeat (gap) @(posedge hclk);
		rd(A_CNT, d1);
		`CHK(nm, e, d1[7:0] - d0[7:0])
	endtask : delta

	task automatic osc_run(input int n);
		repeat (n)
		begin
			osc <= 1'b1;
			@(posedge hclk);
			osc <= 1'b0;
			repeat (2) @(posedge hclk);
		end
		repeat (3) @(posedge hclk);
	endtask : osc_run

	initial
	begin
		hresetn = 1'b0;
		hsel = 1'b1;
		haddr = 32'h0000_0000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0000_0000;
		osc = 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		chk_rd(A_OPT, 32'h0000_00FF, "option_reset");
		chk_rd(A_CNT, 32'h0000_0000, "count_reset");
		chk_rd(A_INT, 32'h0000_0000, "intctl_reset");
		chk_rd(32'h0000_0100, 32'h0000_0000, "unmapped");
		$display("test reset done");
		wr(A_OPT, 8'h08);
		// a delta window spans gap plus three cycles; whole periods keep it phase free
		delta(41, 8'h0B, "timer_rate");
		wr(A_CNT, 8'h10);
		chk_rd(A_CNT, 32'h0000_0010, "inhibit");
		$display("test timer done");
		wr(A_CNT, 8'hFD);
		chk_rd(A_INT, 32'h0000_0000, "flag_early");
		repeat (40) @(posedge hclk);
		chk_rd(A_INT, 32'h0000_0004, "flag_set");
		`CHK("irq_masked", 1'b0, irq)
		wr(A_INT, 8'h20);
		chk_rd(A_INT, 32'h0000_0024, "flag_sticky");
		`CHK("irq_on", 1'b1, irq)
		wr(A_INT, 8'h24);
		repeat (200) @(posedge hclk);
		chk_rd(A_INT, 32'h0000_0020, "flag_clear");
		`CHK("irq_off", 1'b0, irq)
		wr(A_INT, 8'h00);
		$display("test overflow done");
		for (int r = 0; r < 3; r++)
		begin
			wr(A_OPT, {5'h00, 3'(r)});
			// let the sampler settle on the new rate bit before the window opens
			repeat (8) @(posedge hclk);
			delta((20 << (r + 1)) - 3, 8'h05, "prescaled_rate");
		end
		wr(A_OPT, 8'h07);
		wr(A_CNT, 8'h00);
		// rate bit first rises after half the ratio, some 512 cycles on
		repeat (490) @(posedge hclk);
		chk_rd(A_CNT, 32'h0000_0000, "prescaler_cleared");
		repeat (60) @(posedge hclk);
		chk_rd(A_CNT, 32'h0000_0001, "prescaled_tick");
		chk_rd(A_OPT, 32'h0000_0007, "assign_kept");
		$display("test prescaler done");
		wr(A_OPT, 8'h08);
		wr(A_CTL, 8'h01);
		delta(40, 8'h00, "sleep_frozen");
		wr(A_CTL, 8'h00);
		$display("test sleep done");
		// three pulses then a final rise: rising mode sees four, falling three;
		// the pin rests at the level that the new edge select takes as inactive
		for (int s = 0; s < 2; s++)
		begin
			src.level(1'(s));
			wr(A_OPT, s ? 8'h38 : 8'h28);
			rd(A_CNT, d0);
			src.pulses(3);
			src.level(1'b1);
			rd(A_CNT, d1);
			`CHK("edge_count", s ? 8'h03 : 8'h04, d1[7:0] - d0[7:0])
			src.level(1'b0);
		end
		// counter mode through the prescaler at 1:2
		wr(A_OPT, 8'h20);
		wr(A_CNT, 8'h00);
		repeat (10) @(posedge hclk);
		src.pulses(4);
		chk_rd(A_CNT, 32'h0000_0002, "edge_prescaled");
		$display("test counter done");
		wr(A_OPT, 8'h0A);
		n_clr = 0;
		wr(A_CTL, 8'h02);
		repeat (3) @(posedge hclk);
		`CHK("wd_clear", 1, n_clr)
		n_tick = 0;
		osc_run(16);
		`CHK("wd_divided", 4, n_tick)
		wr(A_OPT, 8'h02);
		n_tick = 0;
		osc_run(16);
		`CHK("wd_undivided", 16, n_tick)
		`CHK("hresp_okay", 0, n_resp)
		$display("test watchdog done");
		conclude();
	end
endmodule : tb
`default_nettype wire
